// ==== logic/ast_pkg.sv ====
package ast_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   // Oversampling ratio of both serial clocks
   localparam int OVERSAMPLE = 16;
   localparam logic [4:0] HALF_BIT_CNT = 5'h07;
   localparam logic [4:0] FULL_BIT_CNT = 5'h0F;
   localparam logic [4:0] HALF_STOP_CNT = 5'h07;
   // Delay from falling edge of master reset to shift-empty high
   localparam int MR_DELAY_CYCLES = 18;
   localparam logic [4:0] MR_DELAY = 5'h12;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   localparam int CW_LEN0_POS = 0;
   localparam int CW_LEN1_POS = 1;
   localparam int CW_PI_POS = 2;
   localparam int CW_EVEN_POS = 3;
   localparam int CW_STOP_POS = 4;

   typedef struct packed
   {
      logic stopSel;
      logic evenPar;
      logic parInhibit;
      logic [1:0] lenSel;
   } ast_ctrl_t;

   typedef struct packed
   {
      logic parityError;
      logic framingError;
      logic overrunError;
      logic rxDataReady;
      logic txHoldEmpty;
   } ast_status_t;
endpackage

// ==== logic/ast_fifo.sv ====
`timescale 1ns/1ps
module ast_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr;
   logic [AW:0] rdPtr;
   logic [AW:0] used;

   assign used = wrPtr - rdPtr;
   assign inReady = (used < (AW+1)'(DEPTH));
   assign outValid = (used != '0);
   assign outData = mem[rdPtr[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         wrPtr <= '0;
      else if (inValid && inReady)
      begin
         mem[wrPtr[AW-1:0]] <= inData;
         wrPtr <= wrPtr + 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdPtr <= '0;
      else if (outValid && outReady)
         rdPtr <= rdPtr + 1'b1;
   end

   a_fifo_no_over: assert property (@(posedge clk) disable iff (sys_rst)
      used <= (AW+1)'(DEPTH))
      else $error("fifo count beyond depth");
endmodule

// ==== logic/async_serial_transceiver.sv ====
`timescale 1ns/1ps
// Functional notes
// - Length selects give 5, 6, 7, 8 bits
// - Parity inhibit drops parity, holds error low
// - Stop select: 1.5 for 5-bit, else 2
// - Control follows while strobe high, latched falling
// - Holding outputs float when disable high
// - Short characters right justified to bit one
// - Parity error on parity mismatch
// - Framing error on bad first stop bit
// - Overrun when ready still set at transfer
// - Status disable floats the five flags
// - Receiver samples on 16x receive clock
// - Low clear input drops data ready
// - Data ready set after holding transfer
// - Reset clears flags; shift-empty after 18 cycles
// - Reset keeps receive holding contents
// - Hold empty once passed to shift register; code raises it once passed to the FIFO with room left
// - Low load strobe captures transmit data
// - Load rising edge starts transfer, back to back
// - Shift empty only after stop bits done
// - Start, data, parity, stop shifted serially
// - Unused upper transmit inputs ignored
// - Even select chooses even, else odd parity
// - Transmitter shifts on 16x transmit clock
// - Start centre count 7.5, resume mid stop
module async_serial_transceiver
   import ast_pkg::*;
#(
   parameter int FIFO_W = ast_pkg::DATA_W,
   parameter int FIFO_D = ast_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic master_reset,
   input wire logic ctrl_word_load,
   input wire logic char_len_sel0,
   input wire logic char_len_sel1,
   input wire logic parity_inhibit,
   input wire logic even_parity_sel,
   input wire logic stop_bits_sel,
   input wire logic rx_clk_16x,
   input wire logic tx_clk_16x,
   input wire logic rx_serial_in,
   input wire logic rx_ready_clear_n,
   input wire logic rx_hold_out_disable,
   input wire logic status_out_disable,
   input wire logic tx_hold_load_n,
   input wire logic [7:0] tx_hold_in,
   output logic [7:0] rx_hold_out,
   output logic rx_hold_out_oe_n,
   output ast_pkg::ast_status_t status,
   output logic status_oe_n,
   output logic tx_shift_empty,
   output logic tx_serial_out
);
   import ast_pkg::*;

   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ast_rx_state_t;
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ast_tx_state_t;

   ast_ctrl_t ctrl;
   ast_ctrl_t ctrlIn;
   logic [3:0] charLen;
   logic rxPrev;
   logic txPrev;
   logic rxTick;
   logic txTick;
   logic loadPrev;
   logic [4:0] mrCount;
   logic mrPrev;

   assign ctrlIn = '{stopSel: stop_bits_sel, evenPar: even_parity_sel,
                     parInhibit: parity_inhibit, lenSel: {char_len_sel1, char_len_sel0}};
   assign charLen = 4'h5 + {2'h0, ctrl.lenSel};

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ctrl <= CTRL_RESET;
      else if (ctrl_word_load)
         ctrl <= ctrlIn;
   end

   // Edge detect on the 16x clocks, sampled as ordinary inputs
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rxPrev <= 1'b0;
         txPrev <= 1'b0;
         loadPrev <= 1'b1;
         mrPrev <= 1'b0;
      end
      else
      begin
         rxPrev <= rx_clk_16x;
         txPrev <= tx_clk_16x;
         loadPrev <= tx_hold_load_n;
         mrPrev <= master_reset;
      end
   end
   assign rxTick = rx_clk_16x && !rxPrev;
   assign txTick = tx_clk_16x && !txPrev;

   // Transmit holding buffer through the FIFO
   logic [7:0] holdData;
   logic holdValid;
   logic holdReady;
   logic loadRise;
   logic [7:0] txMasked;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [FIFO_W-1:0] fifoOutData;

   always_comb
   begin
      txMasked = tx_hold_in;
      for (int i = 5; i < 8; i++)
         if (i >= int'(charLen))
            txMasked[i] = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         holdData <= 8'h00;
      else if (!tx_hold_load_n)
         holdData <= txMasked;
   end
   assign loadRise = tx_hold_load_n && !loadPrev;

   always_ff @(posedge clk)
   begin
      if (sys_rst || master_reset)
         holdValid <= 1'b0;
      else if (loadRise)
         holdValid <= 1'b1;
      else if (holdReady)
         holdValid <= 1'b0;
   end

   ast_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) txFifo (
      .clk(clk),
      .sys_rst(sys_rst || master_reset),
      .inValid(holdValid),
      .inReady(fifoInReady),
      .inData(FIFO_W'(holdData)),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );
   assign holdReady = fifoInReady;

   // Transmitter
   ast_tx_state_t txState;
   logic [7:0] txShift;
   logic [3:0] txBit;
   logic [4:0] txPhase;
   logic txParity;
   logic [4:0] txStopLen;
   logic txStopHalf;
   logic mrDone;

   assign txStopHalf = ctrl.stopSel && (ctrl.lenSel == 2'b00);
   assign fifoOutReady = (txState == TX_IDLE) && mrDone;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         mrCount <= 5'h00;
      else if (master_reset)
         mrCount <= 5'h00;
      else if (mrCount != MR_DELAY)
         mrCount <= mrCount + 5'h01;
   end
   assign mrDone = (mrCount == MR_DELAY);

   always_ff @(posedge clk)
   begin
      if (sys_rst || master_reset)
      begin
         txState <= TX_IDLE;
         txShift <= 8'h00;
         txBit <= 4'h0;
         txPhase <= 5'h00;
         txParity <= 1'b0;
         txStopLen <= 5'h00;
         tx_serial_out <= 1'b1;
      end
      else
         case (txState)
            TX_IDLE:
            begin
               tx_serial_out <= 1'b1;
               if (fifoOutValid && mrDone)
               begin
                  txShift <= fifoOutData[7:0];
                  txParity <= ^fifoOutData[7:0] ^ ~ctrl.evenPar;
                  txPhase <= 5'h00;
                  txState <= TX_START;
                  tx_serial_out <= 1'b0;
               end
            end
            TX_START:
               if (txTick)
               begin
                  txPhase <= txPhase + 5'h01;
                  if (txPhase == FULL_BIT_CNT)
                  begin
                     txPhase <= 5'h00;
                     txBit <= 4'h0;
                     tx_serial_out <= txShift[0];
                     txShift <= {1'b0, txShift[7:1]};
                     txState <= TX_DATA;
                  end
               end
            TX_DATA:
               if (txTick)
               begin
                  txPhase <= txPhase + 5'h01;
                  if (txPhase == FULL_BIT_CNT)
                  begin
                     txPhase <= 5'h00;
                     txBit <= txBit + 4'h1;
                     if (txBit + 4'h1 == charLen)
                     begin
                        txStopLen <= ctrl.stopSel ? (txStopHalf ? 5'h17 : 5'h1F) : FULL_BIT_CNT;
                        if (ctrl.parInhibit)
                        begin
                           tx_serial_out <= 1'b1;
                           txState <= TX_STOP;
                        end
                        else
                        begin
                           tx_serial_out <= txParity;
                           txState <= TX_PAR;
                        end
                     end
                     else
                     begin
                        tx_serial_out <= txShift[0];
                        txShift <= {1'b0, txShift[7:1]};
                     end
                  end
               end
            TX_PAR:
               if (txTick)
               begin
                  txPhase <= txPhase + 5'h01;
                  if (txPhase == FULL_BIT_CNT)
                  begin
                     txPhase <= 5'h00;
                     tx_serial_out <= 1'b1;
                     txState <= TX_STOP;
                  end
               end
            TX_STOP:
               if (txTick)
               begin
                  txPhase <= txPhase + 5'h01;
                  if (txPhase == txStopLen)
                     txState <= TX_IDLE;
               end
            default: txState <= TX_IDLE;
         endcase
   end
   assign tx_shift_empty = (txState == TX_IDLE) && !fifoOutValid && mrDone;

   // Receiver
   ast_rx_state_t rxState;
   logic [7:0] rxShift;
   logic [3:0] rxBit;
   logic [4:0] rxPhase;
   logic rxParity;
   logic [7:0] rxHold;
   logic rxDone;
   logic rxParErr;
   logic rxFrameErr;
   logic flagPar, flagFrame, flagOver, flagReady, flagHoldEmpty;

   always_ff @(posedge clk)
   begin
      if (sys_rst || master_reset)
      begin
         rxState <= RX_IDLE;
         rxShift <= 8'h00;
         rxBit <= 4'h0;
         rxPhase <= 5'h00;
         rxParity <= 1'b0;
      end
      else if (rxTick)
         case (rxState)
            RX_IDLE:
               if (!rx_serial_in)
               begin
                  rxPhase <= 5'h00;
                  rxState <= RX_START;
               end
            RX_START:
            begin
               rxPhase <= rxPhase + 5'h01;
               if (rxPhase == HALF_BIT_CNT)
               begin
                  rxPhase <= 5'h00;
                  rxBit <= 4'h0;
                  rxShift <= 8'h00;
                  rxState <= rx_serial_in ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA:
            begin
               rxPhase <= rxPhase + 5'h01;
               if (rxPhase == FULL_BIT_CNT)
               begin
                  rxPhase <= 5'h00;
                  rxShift[rxBit[2:0]] <= rx_serial_in;
                  rxBit <= rxBit + 4'h1;
                  if (rxBit + 4'h1 == charLen)
                     rxState <= ctrl.parInhibit ? RX_STOP : RX_PAR;
               end
            end
            RX_PAR:
            begin
               rxPhase <= rxPhase + 5'h01;
               if (rxPhase == FULL_BIT_CNT)
               begin
                  rxPhase <= 5'h00;
                  rxParity <= rx_serial_in;
                  rxState <= RX_STOP;
               end
            end
            RX_STOP:
            begin
               rxPhase <= rxPhase + 5'h01;
               if (rxPhase == FULL_BIT_CNT)
                  rxState <= RX_IDLE;
            end
            default: rxState <= RX_IDLE;
         endcase
   end
   assign rxDone = rxTick && (rxState == RX_STOP) && (rxPhase == FULL_BIT_CNT);
   assign rxFrameErr = !rx_serial_in;
   // Even parity wants an even count of ones over data and parity, odd wants odd
   assign rxParErr = !ctrl.parInhibit && ((^rxShift ^ rxParity) == ctrl.evenPar);

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rxHold <= 8'h00;
      else if (rxDone && !master_reset)
         rxHold <= rxShift;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || master_reset)
      begin
         flagPar <= 1'b0;
         flagFrame <= 1'b0;
         flagOver <= 1'b0;
      end
      else if (rxDone)
      begin
         flagPar <= rxParErr;
         flagFrame <= rxFrameErr;
         flagOver <= flagReady;
      end
   end

   // Set wins over the clear input
   always_ff @(posedge clk)
   begin
      if (sys_rst || master_reset)
         flagReady <= 1'b0;
      else if (rxDone)
         flagReady <= 1'b1;
      else if (!rx_ready_clear_n)
         flagReady <= 1'b0;
   end

   assign flagHoldEmpty = !holdValid && fifoInReady;
   assign status = '{parityError: flagPar, framingError: flagFrame, overrunError: flagOver,
                     rxDataReady: flagReady, txHoldEmpty: flagHoldEmpty};
   assign status_oe_n = status_out_disable;
   assign rx_hold_out = rxHold;
   assign rx_hold_out_oe_n = rx_hold_out_disable;

   a_tx_idle_high: assert property (@(posedge clk) disable iff (sys_rst)
      (txState == TX_IDLE && !$past(fifoOutValid)) |-> tx_serial_out)
      else $error("line not idle high");
   a_pe_inhibit: assert property (@(posedge clk) disable iff (sys_rst)
      (ctrl.parInhibit && rxDone) |=> !flagPar)
      else $error("parity error while inhibited");
   a_dr_set: assert property (@(posedge clk) disable iff (sys_rst || master_reset)
      rxDone |=> flagReady)
      else $error("data ready not set");
   a_dr_clear: assert property (@(posedge clk) disable iff (sys_rst)
      (!rx_ready_clear_n && !rxDone) |=> !flagReady)
      else $error("data ready not cleared");
   a_overrun_set: assert property (@(posedge clk) disable iff (sys_rst || master_reset)
      (rxDone && flagReady) |=> flagOver)
      else $error("overrun missed");
   a_mr_flags: assert property (@(posedge clk) disable iff (sys_rst)
      master_reset |=> !flagReady && !flagPar && !flagFrame && !flagOver)
      else $error("master reset did not clear flags");
   sequence s_mr_fall;
      mrPrev && !master_reset;
   endsequence
   a_mr_delay: assert property (@(posedge clk) disable iff (sys_rst || master_reset)
      s_mr_fall |-> !tx_shift_empty [*8])
      else $error("shift empty too early");
   a_hold_keep: assert property (@(posedge clk) disable iff (sys_rst)
      master_reset |=> rxHold == $past(rxHold))
      else $error("holding register changed by reset");
   a_ctrl_follow: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_word_load |=> ctrl == $past(ctrlIn))
      else $error("control not following");
endmodule

// ==== tb/ast_line_model.sv ====
`timescale 1ns/1ps
module ast_line_model (
   input wire logic clk,
   input wire logic txLine,
   output logic rxClk,
   output logic txClk,
   output logic rxLine
);
   int nBits = 8;
   bit parOn = 0;
   int txTicks = 0;
   logic [10:0] gotRaw[$];
   int gotStart[$];

   initial
   begin
      rxClk = 1'h0;
      txClk = 1'h0;
      rxLine = 1'h1;
   end

   // Free-running 16x bit clocks, slightly apart in rate
   always #20 txClk = ~txClk;
   always #21 rxClk = ~rxClk;

   always @(posedge txClk) txTicks++;

   // Samples each transmitted bit at its centre; stop bit lands in the top used slot
   initial
   begin : decode
      logic [10:0] raw;
      forever
      begin
         @(negedge txLine);
         gotStart.push_back(txTicks);
         raw = '0;
         repeat (8) @(posedge txClk);
         for (int i = 0; i < nBits + parOn + 1; i++)
         begin
            repeat (16) @(posedge txClk);
            raw[i] = txLine;
         end
         gotRaw.push_back(raw);
      end
   end

   // Start bit, then len bits of 16 ticks each, then idle high
   task automatic send_frame(input logic [10:0] bits, input int len);
      @(posedge rxClk);
      rxLine <= 1'h0;
      for (int i = 0; i <= len; i++)
      begin
         repeat (16) @(posedge rxClk);
         rxLine <= (i == len) ? 1'h1 : bits[i];
      end
      repeat (16) @(posedge rxClk);
   endtask
endmodule

// ==== tb/async_serial_transceiver_test.sv ====
`timescale 1ns/1ps
module async_serial_transceiver_test;
   import ast_pkg::*;
   logic clk, sys_rst, masterReset, ctrlLoad, lenSel0, lenSel1, parInhibit, evenSel, stopSel;
   logic rxClk, txClk, rxLine, readyClearN, holdOutDis, statusDis, loadN;
   logic [7:0] txData, rxHold, d0;
   logic rxHoldOeN, statusOeN, shiftEmpty, txLine;
   ast_status_t status;
   int errCount = 0;
   int cmpCount = 0;
   int acc, n, p;

   async_serial_transceiver #(.FIFO_W(DATA_W), .FIFO_D(FIFO_DEPTH)) async_serial_transceiver_inst (
      .clk(clk), .sys_rst(sys_rst), .master_reset(masterReset), .ctrl_word_load(ctrlLoad),
      .char_len_sel0(lenSel0), .char_len_sel1(lenSel1), .parity_inhibit(parInhibit),
      .even_parity_sel(evenSel), .stop_bits_sel(stopSel), .rx_clk_16x(rxClk),
      .tx_clk_16x(txClk), .rx_serial_in(rxLine), .rx_ready_clear_n(readyClearN),
      .rx_hold_out_disable(holdOutDis), .status_out_disable(statusDis),
      .tx_hold_load_n(loadN), .tx_hold_in(txData), .rx_hold_out(rxHold),
      .rx_hold_out_oe_n(rxHoldOeN), .status(status), .status_oe_n(statusOeN),
      .tx_shift_empty(shiftEmpty), .tx_serial_out(txLine)
   );

   ast_line_model ast_line_model_inst (
      .clk(clk), .txLine(txLine), .rxClk(rxClk), .txClk(txClk), .rxLine(rxLine)
   );

   initial clk = 1'h0;
   always #5 clk = ~clk;

   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      cmpCount++;
      if (got !== exp)
      begin
         errCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp)
      begin
         errCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic giveVerdict;
      $display("Compares %0d, mismatches %0d", cmpCount, errCount);
      if (errCount == 0 && cmpCount > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Bounded wait on shift-empty (which 0) or data ready (which 1)
   task automatic wait_for(input int which, input int bound);
      int k;
      k = 0;
      // Realign to just after a clock edge, callers may come from the serial clock
      step(1);
      while ((which ? status.rxDataReady : shiftEmpty) !== 1'h1)
      begin
         step(1);
         k++;
         if (k > bound)
         begin
            chk_bit(1'h0, 1'h1);
            giveVerdict();
         end
      end
   endtask

   // Latches a word, then scrambles the inputs so only the latched copy can act
   task automatic set_ctrl(input logic [1:0] len, input logic pi, even, stop);
      {lenSel1, lenSel0, parInhibit, evenSel, stopSel} = {len, pi, even, stop};
      ctrlLoad = 1'h1;
      step(1);
      ctrlLoad = 1'h0;
      step(1);
      {lenSel1, lenSel0, parInhibit, evenSel, stopSel} = ~{len, pi, even, stop};
      ast_line_model_inst.nBits = 5 + len;
      ast_line_model_inst.parOn = !pi;
   endtask

   task automatic load_char(input logic [7:0] d);
      txData = d;
      loadN = 1'h0;
      step(1);
      loadN = 1'h1;
      step(3);
   endtask

   // Data bits masked to length, then parity if enabled, then one high stop bit
   function automatic logic [10:0] frame(input logic [7:0] d, input int len, input logic pi, even);
      logic [7:0] m;
      logic par;
      m = d & ((8'h01 << len) - 8'h01);
      par = even ? ^m : ~^m;
      frame = {3'h0, m} | (pi ? 11'h000 : {10'h000, par} << len);
      frame = frame | (11'h001 << (len + (pi ? 0 : 1)));
   endfunction

   initial
   begin
      sys_rst = 1'h1;
      {masterReset, ctrlLoad, lenSel0, lenSel1, parInhibit, evenSel, stopSel} = 7'h00;
      {readyClearN, holdOutDis, statusDis, loadN} = 4'h9;
      txData = 8'h00;
      step(5);
      sys_rst = 1'h0;
      masterReset = 1'h1;
      step(2);
      masterReset = 1'h0;
      step(14);
      chk_bit(shiftEmpty, 1'h0);
      step(7);
      chk_bit(shiftEmpty, 1'h1);
      chk_val(status[4:1], 4'h0);
      for (int i = 0; i < 4; i++)
      begin
         {statusDis, holdOutDis} = 2'(i);
         step(1);
         chk_bit(rxHoldOeN, i[0]);
         chk_bit(statusOeN, i[1]);
      end
      {statusDis, holdOutDis} = 2'h0;
      // Two back-to-back characters in every length and three of the parity/stop modes
      for (int len = 0; len < 4; len++)
         for (int md = 0; md < 3; md++)
         begin
            set_ctrl(len[1:0], md == 0, md == 1, md != 1);
            ast_line_model_inst.gotRaw.delete();
            ast_line_model_inst.gotStart.delete();
            d0 = 8'hE9 + 8'(len * 3 + md);
            n = 5 + len;
            p = (md != 0) ? 1 : 0;
            load_char(d0);
            load_char(~d0);
            chk_bit(shiftEmpty, 1'h0);
            chk_bit(status.txHoldEmpty, 1'h1);
            wait_for(0, 4000);
            chk_val(ast_line_model_inst.gotRaw[0], frame(d0, n, md == 0, md == 1));
            chk_val(ast_line_model_inst.gotRaw[1], frame(~d0, n, md == 0, md == 1));
            chk_val(ast_line_model_inst.gotStart[1] - ast_line_model_inst.gotStart[0],
               16 * (1 + n + p) + ((md == 1) ? 16 : ((n == 5) ? 24 : 32)));
            chk_bit(txLine, 1'h1);
         end
      // Receive: clean, parity fault, then framing fault with overrun
      set_ctrl(2'h2, 1'h0, 1'h1, 1'h0);
      ast_line_model_inst.send_frame(frame(8'hD5, 7, 1'h0, 1'h1), 9);
      wait_for(1, 2000);
      chk_val(rxHold, 8'h55);
      chk_val(status[4:1], 4'h1);
      readyClearN = 1'h0;
      step(1);
      readyClearN = 1'h1;
      step(1);
      chk_bit(status.rxDataReady, 1'h0);
      ast_line_model_inst.send_frame(frame(8'h2A, 7, 1'h0, 1'h1) ^ 11'h080, 9);
      wait_for(1, 2000);
      chk_val(status[4:1], 4'h9);
      ast_line_model_inst.send_frame(frame(8'h33, 7, 1'h0, 1'h1) ^ 11'h100, 9);
      step(2);
      chk_val(status[4:1], 4'h7);
      chk_val(rxHold, 8'h33);
      masterReset = 1'h1;
      step(2);
      masterReset = 1'h0;
      step(21);
      chk_val(status[4:1], 4'h0);
      chk_val(rxHold, 8'h33);
      set_ctrl(2'h0, 1'h1, 1'h0, 1'h0);
      ast_line_model_inst.send_frame(frame(8'hFF, 5, 1'h1, 1'h0), 6);
      wait_for(1, 2000);
      chk_val(rxHold, 8'h1F);
      chk_val(status[4:1], 4'h1);
      // Fill the transmit queue until it refuses, then let it drain
      ast_line_model_inst.gotRaw.delete();
      acc = 0;
      while (status.txHoldEmpty === 1'h1 && acc < 24)
      begin
         load_char(8'(acc));
         acc++;
      end
      chk_bit(acc >= FIFO_DEPTH && acc < 24, 1'h1);
      // The holding stage keeps this extra character until the queue has room
      load_char(8'h1F);
      wait_for(0, 20000);
      chk_val(ast_line_model_inst.gotRaw.size(), acc + 1);
      chk_val(ast_line_model_inst.gotRaw[acc - 1], frame(8'(acc - 1), 5, 1'h1, 1'h0));
      chk_val(ast_line_model_inst.gotRaw[acc], frame(8'h1F, 5, 1'h1, 1'h0));
      giveVerdict();
   end
endmodule
